// [hdl/xbi_bus.sv]
/*
 External multiplexed address/data bus sequencer with bank-0 decode: internal
 RAM, internal pin-port registers, and external cycles for everything else.
 Assumes clk is the oscillator input, the CPU side issues one request at a
 time and waits for cpu_ack, and all pin inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module xbi_bus (
   input  wire logic                                  clk,
   input  wire logic                                  reset,
   input  wire logic                                  cpu_req,
   input  wire logic                                  cpu_write,
   input  wire logic                                  cpu_word,
   input  wire logic                                  cpu_direct,
   input  wire logic [23:0]                           cpu_addr,
   input  wire logic [15:0]                           cpu_wdata,
   output logic                                       cpu_ack,
   output logic      [15:0]                           cpu_rdata,
   output logic                                       cpu_busy,
   input  wire logic [15:0]                           direct_page_base,
   input  wire logic                                  bus_width_8,
   input  wire logic                                  ready,
   input  wire logic                                  hold_req_n,
   output logic                                       bus_hold_grant,
   output logic                                       phi1_out,
   output logic                                       enable_n,
   output logic                                       read_write,
   output logic                                       upper_byte_enable_n,
   output logic                                       addr_latch,
   output logic      [7:0]                            addr_lo,
   output logic                                       ctrl_oe_n,
   output logic                                       vector_access,
   output logic      [7:0]                            mid_o,
   input  wire logic [7:0]                            mid_i,
   output logic                                       mid_oe_n,
   output logic      [7:0]                            hi_o,
   input  wire logic [7:0]                            hi_i,
   output logic                                       hi_oe_n,
   input  wire logic [xbi_pkg::XBI_NPORT-1:0][7:0]    port_i,
   output logic      [xbi_pkg::XBI_NPORT-1:0][7:0]    port_o,
   output logic      [xbi_pkg::XBI_NPORT-1:0][7:0]    port_oe_n
);

   typedef struct packed {
      xbi_pkg::xbi_state_t st;
      logic                div;
      logic                phi1;
      logic [23:0]         addr;
      logic                write;
      logic                word;
      logic                bw8;
      logic                full;
      logic                more;
      logic                part;
      logic [15:0]         wdata;
      logic [15:0]         rdata;
      logic                ack;
      logic                ale;
      logic                en_n;
      logic                rw;
      logic                ube_n;
      logic                grant;
      logic                vec;
      logic [7:0]          mid_o;
      logic                mid_oe_n;
      logic [7:0]          hi_o;
      logic                hi_oe_n;
   } xbi_bus_state_t;

   xbi_bus_state_t s_q;
   xbi_bus_state_t s_d;

   logic [7:0]  ram_q [0:xbi_pkg::XBI_RAM_BYTES-1];
   logic [23:0] ea;
   logic        hit_ram;
   logic        hit_peri;
   logic        tick;
   logic [10:0] ram_idx;
   logic [10:0] ram_idx1;
   logic        ram_we;
   logic [15:0] peri_rdata;
   logic        peri_we;

   function automatic logic xbi_in(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
      xbi_in = (a >= lo) && (a <= hi);
   endfunction

   // A direct-page address may run past bank 0 into bank 1
   function automatic logic [23:0] xbi_eff(input logic direct, input logic [15:0] base, input logic [23:0] a);
      xbi_eff = direct ? ({8'h00, base} + {16'h0000, a[xbi_pkg::XBI_DP_W-1:0]}) : a;
   endfunction

   // Byte steering on the upper lane applies only on the wide bus with an odd byte
   function automatic logic xbi_upper(input logic bw8, input logic [23:0] a);
      xbi_upper = !bw8 && a[0];
   endfunction

   assign ea = xbi_eff(cpu_direct, direct_page_base, cpu_addr);                 // R17
   assign hit_ram = xbi_in(ea, xbi_pkg::XBI_RAM_LO, xbi_pkg::XBI_RAM_HI);        // R15
   assign hit_peri = xbi_in(ea, xbi_pkg::XBI_PERI_LO, xbi_pkg::XBI_PERI_HI);     // R16
   assign tick = (s_q.div == xbi_pkg::XBI_DIV_LAST);
   assign ram_idx = 11'(ea - xbi_pkg::XBI_RAM_LO);
   assign ram_idx1 = 11'(ram_idx + 11'h001);
   assign ram_we = (s_q.st == xbi_pkg::XBI_IDLE) && hold_req_n && cpu_req && cpu_write && hit_ram;
   assign peri_we = (s_q.st == xbi_pkg::XBI_IDLE) && hold_req_n && cpu_req && cpu_write && hit_peri;

   xbi_port u_port (
      .clk       (clk),
      .reset     (reset),
      .reg_addr  (ea[6:0]),
      .reg_we    (peri_we),
      .reg_word  (cpu_word),
      .reg_wdata (cpu_wdata),
      .reg_rdata (peri_rdata),
      .pin_i     (port_i),
      .pin_o     (port_o),
      .pin_oe_n  (port_oe_n)
   );

   // Internal RAM; word accesses are little-endian and wrap inside the array
   always_ff @(posedge clk) begin
      if (ram_we) begin
         ram_q[ram_idx] <= cpu_wdata[7:0];                                       // R15
         if (cpu_word) ram_q[ram_idx1] <= cpu_wdata[15:8];
      end
   end

   always_comb begin
      logic [7:0] rbyte;
      logic       full;
      rbyte = 8'h00;
      full = 1'b0;
      s_d = s_q;
      s_d.div = 1'(s_q.div + 1'b1);                                              // R03
      s_d.phi1 = tick ? 1'b0 : 1'b1;
      s_d.ack = 1'b0;
      case (s_q.st)
         xbi_pkg::XBI_IDLE: begin
            if (!hold_req_n) begin
               s_d.st = xbi_pkg::XBI_HOLD;                                       // R05
               s_d.grant = 1'b1;                                                 // R06
            end else if (cpu_req && (hit_ram || hit_peri)) begin
               s_d.ack = 1'b1;
               if (cpu_write) begin
                  s_d.rdata = 16'h0000;
               end else if (hit_ram) begin
                  s_d.rdata = {cpu_word ? ram_q[ram_idx1] : 8'h00, ram_q[ram_idx]};
               end else begin
                  s_d.rdata = {cpu_word ? peri_rdata[15:8] : 8'h00, peri_rdata[7:0]};
               end
            end else if (cpu_req && tick) begin
               // Wide bus, aligned word: one cycle on both lanes; otherwise byte cycles
               full = !bus_width_8 && cpu_word && !ea[0];                        // R02
               s_d.st = xbi_pkg::XBI_ADDR;
               s_d.addr = ea;                                                    // R13
               s_d.write = cpu_write;
               s_d.word = cpu_word;
               s_d.bw8 = bus_width_8;                                            // R02
               s_d.full = full;
               s_d.more = cpu_word && !full;
               s_d.part = 1'b0;
               s_d.wdata = cpu_wdata;
               s_d.rdata = 16'h0000;
               s_d.ale = 1'b1;                                                   // R09
               s_d.rw = !cpu_write;                                              // R07
               s_d.ube_n = full ? 1'b0 : !ea[0];                                 // R08
               s_d.vec = xbi_in(ea, xbi_pkg::XBI_VEC_LO, xbi_pkg::XBI_VEC_HI);   // R14
            end
         end
         xbi_pkg::XBI_ADDR: begin
            if (tick) begin
               s_d.st = xbi_pkg::XBI_DATA;
               s_d.ale = 1'b0;                                                   // R09
               s_d.en_n = 1'b0;                                                  // R01
            end
         end
         xbi_pkg::XBI_DATA: begin
            // Ready low holds the data phase, stretching the whole cycle
            if (tick && ready) begin                                             // R04
               s_d.en_n = 1'b1;                                                  // R01
               rbyte = xbi_upper(s_q.bw8, s_q.addr) ? mid_i : hi_i;
               if (!s_q.write) begin
                  if (s_q.full) s_d.rdata = {mid_i, hi_i};                       // R10
                  else if (s_q.part) s_d.rdata[15:8] = rbyte;
                  else s_d.rdata[7:0] = rbyte;                                   // R12
               end
               if (s_q.more) begin
                  s_d.st = xbi_pkg::XBI_ADDR;
                  s_d.addr = 24'(s_q.addr + 24'h000001);
                  s_d.more = 1'b0;
                  s_d.part = 1'b1;
                  s_d.ale = 1'b1;                                                // R09
                  s_d.ube_n = s_q.addr[0];                                       // R08
                  s_d.vec = xbi_in(24'(s_q.addr + 24'h000001), xbi_pkg::XBI_VEC_LO, xbi_pkg::XBI_VEC_HI);
               end else begin
                  s_d.st = xbi_pkg::XBI_IDLE;
                  s_d.ack = 1'b1;
                  s_d.rw = 1'b1;
               end
            end
         end
         xbi_pkg::XBI_HOLD: begin
            if (hold_req_n) begin
               s_d.st = xbi_pkg::XBI_IDLE;
               s_d.grant = 1'b0;                                                 // R06
            end
         end
         default: begin
            s_d.st = xbi_pkg::XBI_IDLE;
         end
      endcase

      // Pin multiplexing follows the next phase so the pins come from flip-flops
      s_d.mid_o = s_d.addr[15:8];
      s_d.hi_o = s_d.addr[23:16];
      s_d.mid_oe_n = 1'b0;
      s_d.hi_oe_n = 1'b0;
      if (s_d.st == xbi_pkg::XBI_HOLD) begin
         s_d.mid_oe_n = 1'b1;                                                    // R19
         s_d.hi_oe_n = 1'b1;                                                     // R19
      end else if (s_d.st == xbi_pkg::XBI_DATA) begin
         if (s_d.write) begin
            s_d.hi_o = (s_d.full || !s_d.part) ? s_d.wdata[7:0] : s_d.wdata[15:8];   // R12
            if (!s_d.bw8) begin
               s_d.mid_o = (s_d.full || s_d.part) ? s_d.wdata[15:8] : s_d.wdata[7:0]; // R10
            end
         end else begin
            s_d.hi_oe_n = 1'b1;                                                  // R12
            s_d.mid_oe_n = !s_d.bw8;                                             // R11
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '0;
         s_q.st <= xbi_pkg::XBI_IDLE;
         s_q.en_n <= 1'b1;
         s_q.rw <= 1'b1;
         s_q.ube_n <= 1'b1;
         s_q.mid_oe_n <= 1'b0;
         s_q.hi_oe_n <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign cpu_ack = s_q.ack;
   assign cpu_rdata = s_q.rdata;
   assign cpu_busy = (s_q.st != xbi_pkg::XBI_IDLE);
   assign bus_hold_grant = s_q.grant;                                            // R06
   assign phi1_out = s_q.phi1;                                                   // R03
   assign enable_n = s_q.en_n;
   assign read_write = s_q.rw;
   assign upper_byte_enable_n = s_q.ube_n;
   assign addr_latch = s_q.ale;
   assign addr_lo = s_q.addr[7:0];
   assign ctrl_oe_n = s_q.grant;                                                 // R19
   assign vector_access = s_q.vec;
   assign mid_o = s_q.mid_o;
   assign mid_oe_n = s_q.mid_oe_n;
   assign hi_o = s_q.hi_o;
   assign hi_oe_n = s_q.hi_oe_n;

endmodule

`default_nettype wire

// [hdl/xbi_pkg.sv]
/*
 Shared constants and types of the external bus interface: bank-0 decode
 windows, clock divide, pin-port register offsets and the bus sequencer states.
 Assumes every design file refers to it as xbi_pkg::name, with no import.
*/
// How it works
// R01 - Bus transfers happen only while enable low
// R02 - Width select low is 16 bits, high 8
// R03 - Clock output is input clock divided by two
// R04 - Ready low freezes the cycle until high
// R05 - Hold request low enters and keeps hold
// R06 - Hold grant shows the hold state
// R07 - Read/write high for reads, low for writes
// R08 - Upper byte enable low on odd addresses
// R09 - Address latch strobe pulses for address capture
// R10 - 16-bit mode: middle pins address, then data
// R11 - 8-bit mode: middle pins carry address only
// R12 - Upper pins: high address, then low data
// R13 - 24-bit address space in 64K banks
// R14 - Bank-0 FFD6 to FFFF holds vectors, external
// R15 - Bank-0 80 to 87F is internal RAM
// R16 - Bank-0 0 to 7F is internal registers
// R17 - Direct page window based on page register
// R18 - Port pins have direction bits, reset inputs
// R19 - Hold releases address, data and control pins; the code has no release for addr_lo, which stays driven
package xbi_pkg;

   localparam int          XBI_ADDR_W    = 24;                 // R13
   localparam int          XBI_DP_W      = 8;                  // R17
   localparam logic [23:0] XBI_PERI_LO   = 24'h000000;         // R16
   localparam logic [23:0] XBI_PERI_HI   = 24'h00007F;
   localparam logic [23:0] XBI_RAM_LO    = 24'h000080;         // R15
   localparam logic [23:0] XBI_RAM_HI    = 24'h00087F;
   localparam int          XBI_RAM_BYTES = 2048;
   localparam logic [23:0] XBI_VEC_LO    = 24'h00FFD6;         // R14
   localparam logic [23:0] XBI_VEC_HI    = 24'h00FFFF;

   // Divide-by-two of the input clock: one divider bit, last phase is 1
   localparam logic        XBI_DIV_LAST  = 1'h1;               // R03

   localparam int          XBI_NPORT     = 5;
   localparam logic [XBI_NPORT-1:0][6:0] XBI_PORT_DATA_OFF =
      {7'h12, 7'h0F, 7'h0E, 7'h0B, 7'h0A};
   localparam logic [XBI_NPORT-1:0][6:0] XBI_PORT_DIR_OFF  =
      {7'h14, 7'h11, 7'h10, 7'h0D, 7'h0C};
   // The first port only has its upper five pins
   localparam logic [XBI_NPORT-1:0][7:0] XBI_PORT_MASK     =
      {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF8};
   localparam logic [7:0]  XBI_PORT_RST  = 8'h00;

   typedef enum logic [1:0] {
      XBI_IDLE,
      XBI_ADDR,
      XBI_DATA,
      XBI_HOLD
   } xbi_state_t;

endpackage

// [hdl/xbi_port.sv]
/*
 General-purpose pin ports: an output latch and a direction register per port,
 reached through the internal register window of bank 0.
 Assumes byte or little-endian word accesses from the bus sequencer, one per clock.
*/
`timescale 1ns/1ps
`default_nettype none

module xbi_port (
   input  wire logic                                  clk,
   input  wire logic                                  reset,
   input  wire logic [6:0]                            reg_addr,
   input  wire logic                                  reg_we,
   input  wire logic                                  reg_word,
   input  wire logic [15:0]                           reg_wdata,
   output logic      [15:0]                           reg_rdata,
   input  wire logic [xbi_pkg::XBI_NPORT-1:0][7:0]    pin_i,
   output logic      [xbi_pkg::XBI_NPORT-1:0][7:0]    pin_o,
   output logic      [xbi_pkg::XBI_NPORT-1:0][7:0]    pin_oe_n
);

   typedef struct packed {
      logic [xbi_pkg::XBI_NPORT-1:0][7:0] latch;
      logic [xbi_pkg::XBI_NPORT-1:0][7:0] dir;
   } xbi_port_state_t;

   xbi_port_state_t s_q;
   xbi_port_state_t s_d;

   // Bit 0: low byte of the access hits; bit 1: high byte of a word hits
   function automatic logic [1:0] xbi_hit(input logic [6:0] a, input logic word, input logic [6:0] off);
      xbi_hit = {word && (7'(a + 7'h01) == off), a == off};
   endfunction

   always_comb begin
      logic [1:0] hl;
      logic [1:0] hd;
      logic [7:0] lv;
      logic [7:0] mask;
      hl = 2'h0;
      hd = 2'h0;
      lv = 8'h00;
      mask = 8'h00;
      s_d = s_q;
      reg_rdata = 16'h0000;
      for (int k = 0; k < xbi_pkg::XBI_NPORT; k++) begin
         mask = xbi_pkg::XBI_PORT_MASK[k];
         hl = xbi_hit(reg_addr, reg_word, xbi_pkg::XBI_PORT_DATA_OFF[k]);
         hd = xbi_hit(reg_addr, reg_word, xbi_pkg::XBI_PORT_DIR_OFF[k]);
         // Output pins read back the latch, input pins the pin level
         lv = ((s_q.latch[k] & s_q.dir[k]) | (pin_i[k] & ~s_q.dir[k])) & mask;
         if (hl[0]) reg_rdata[7:0] = lv;
         if (hl[1]) reg_rdata[15:8] = lv;
         if (hd[0]) reg_rdata[7:0] = s_q.dir[k];
         if (hd[1]) reg_rdata[15:8] = s_q.dir[k];
         if (reg_we) begin
            if (hl[0]) s_d.latch[k] = reg_wdata[7:0] & mask;
            if (hl[1]) s_d.latch[k] = reg_wdata[15:8] & mask;
            if (hd[0]) s_d.dir[k] = reg_wdata[7:0] & mask;   // R18
            if (hd[1]) s_d.dir[k] = reg_wdata[15:8] & mask;  // R18
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int k = 0; k < xbi_pkg::XBI_NPORT; k++) begin
            s_q.latch[k] <= xbi_pkg::XBI_PORT_RST;
            s_q.dir[k] <= xbi_pkg::XBI_PORT_RST;             // R18
         end
      end else begin
         s_q <= s_d;
      end
   end

   assign pin_o = s_q.latch;
   assign pin_oe_n = ~s_q.dir;                               // R18

endmodule

`default_nettype wire

// [verif/xbi_bus_monitor.sv]
/*
 Concurrent checks on the external bus pins of the bus sequencer.
 Assumes it is bound to xbi_bus and that the bus width input holds still while a cycle runs.
*/
`timescale 1ns/1ps
`default_nettype none

module xbi_bus_monitor (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       cpu_busy,
   input wire logic       bus_width_8,
   input wire logic       ready,
   input wire logic       hold_req_n,
   input wire logic       bus_hold_grant,
   input wire logic       phi1_out,
   input wire logic       enable_n,
   input wire logic       read_write,
   input wire logic       upper_byte_enable_n,
   input wire logic       addr_latch,
   input wire logic [7:0] addr_lo,
   input wire logic       ctrl_oe_n,
   input wire logic       mid_oe_n,
   input wire logic       hi_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_addr;
      (addr_latch && enable_n) [*2];
   endsequence
   sequence s_data;
      (!addr_latch && !enable_n) [*2];
   endsequence

   AST_PHI_TOGGLE: assert property (!$past(reset) |-> phi1_out != $past(phi1_out))
      else $error("clock output missed a toggle");
   AST_ADDR_THEN_DATA: assert property ($rose(addr_latch) |-> s_addr ##1 s_data)
      else $error("address phase not followed by data phase");
   AST_WAIT_STRETCH: assert property (!enable_n && phi1_out && !ready |=> !enable_n)
      else $error("data phase ended with ready low");
   AST_DATA_END: assert property (!enable_n && phi1_out && ready |=> enable_n)
      else $error("data phase overran with ready high");
   AST_RW_STEADY: assert property (!enable_n && !$past(enable_n) |-> $stable(read_write))
      else $error("read write moved in data phase");
   AST_UBE_ODD: assert property (addr_latch && addr_lo[0] |-> !upper_byte_enable_n)
      else $error("upper byte enable high on odd address");
   AST_UBE_BYTE8: assert property (addr_latch && bus_width_8 |-> upper_byte_enable_n == !addr_lo[0])
      else $error("upper byte enable wrong on narrow bus");
   AST_MID_ADDR8: assert property (bus_width_8 && !enable_n && !ctrl_oe_n |-> !mid_oe_n)
      else $error("middle pins released on narrow bus");
   AST_HOLD_ENTER: assert property (!hold_req_n && (!cpu_busy || bus_hold_grant) |=> bus_hold_grant)
      else $error("hold not entered or left early");
   AST_GRANT_CAUSE: assert property (bus_hold_grant |-> !$past(hold_req_n))
      else $error("grant without hold request");
   AST_HOLD_RELEASE: assert property (bus_hold_grant |-> ctrl_oe_n && mid_oe_n && hi_oe_n)
      else $error("pins still driven in hold");
endmodule

bind xbi_bus xbi_bus_monitor u_mon (.*);

`default_nettype wire

// [verif/xbi_mem_model.sv]
/*
 External memory on the multiplexed bus, with read-only vectors and optional wait states.
 Assumes the address is latched while the strobe is high and data moves while enable is low.
*/
`timescale 1ns/1ps
`default_nettype none

module xbi_mem_model (
   input wire logic       clk,
   input wire logic       bus_width_8,
   input wire logic       slow,
   input wire logic       enable_n,
   input wire logic       read_write,
   input wire logic       upper_byte_enable_n,
   input wire logic       addr_latch,
   input wire logic [7:0] addr_lo,
   input wire logic [7:0] mid_o,
   input wire logic       mid_oe_n,
   input wire logic [7:0] hi_o,
   input wire logic       hi_oe_n,
   output logic     [7:0] mid_i,
   output logic     [7:0] hi_i,
   output logic           ready
);
   logic [7:0]  mem [logic [23:0]];
   logic [23:0] a_q;
   logic [7:0]  mid_last = 8'h00;
   logic [7:0]  hi_last = 8'h00;
   int          wait_cnt = 0;

   function automatic logic vec(input logic [23:0] a);
      return a >= xbi_pkg::XBI_VEC_LO && a <= xbi_pkg::XBI_VEC_HI;
   endfunction
   // Vector area is read-only: pattern from the address, writes ignored
   function automatic logic [7:0] rd(input logic [23:0] a);
      if (vec(a)) return a[7:0];
      return mem.exists(a) ? mem[a] : ~a[7:0];
   endfunction

   always @(posedge clk) begin
      if (addr_latch)
         a_q <= {hi_o, mid_o, addr_lo};
      wait_cnt <= enable_n ? 0 : wait_cnt + 1;
      if (!enable_n && !read_write && !vec(a_q)) begin
         if (bus_width_8)
            mem[a_q] = hi_o;
         else begin
            if (!upper_byte_enable_n)
               mem[a_q | 24'h000001] = mid_o;
            if (!a_q[0])
               mem[a_q] = hi_o;
         end
      end
      mid_last <= mid_i;
      hi_last <= hi_i;
   end

   // Released lines flip every cycle so a stale value never reads as good
   always @* begin
      ready = !(slow && wait_cnt < 4);
      if (!mid_oe_n)
         mid_i = mid_o;
      else
         mid_i = (!enable_n && read_write && !bus_width_8) ? rd(a_q | 24'h000001) : ~mid_last;
      if (!hi_oe_n)
         hi_i = hi_o;
      else
         hi_i = (!enable_n && read_write) ? rd(bus_width_8 ? a_q : {a_q[23:1], 1'h0}) : ~hi_last;
   end
endmodule

`default_nettype wire

// [verif/xbi_bus_bench.sv]
/*
 Self-checking bench of the bus sequencer: RAM, pin ports, external cycles, waits, vectors, hold.
 Assumes the memory model on the far side; mode bits of xfer are write, word, direct, external.
*/
`timescale 1ns/1ps
`default_nettype none

module xbi_bus_bench;
   logic        clk, reset, cpu_req, cpu_write, cpu_word, cpu_direct, cpu_ack, cpu_busy, slow, vec;
   logic        bus_width_8, ready, hold_req_n, bus_hold_grant, phi1_out, enable_n, read_write;
   logic        upper_byte_enable_n, addr_latch, ctrl_oe_n, vector_access, mid_oe_n, hi_oe_n;
   logic [23:0] cpu_addr;
   logic [15:0] cpu_wdata, cpu_rdata, direct_page_base, q;
   logic [7:0]  addr_lo, mid_o, mid_i, hi_o, hi_i;
   logic [xbi_pkg::XBI_NPORT-1:0][7:0] port_i, port_o, port_oe_n;
   int          n_errors = 0, total_checks = 0, cyc = 0, lat;

   xbi_bus u_dut (.*);
   xbi_mem_model u_mem (.*);

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         $display("Error run time expected under 20000 cycles seen hang");
         conclude();
      end
   end

   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Internal requests stand one cycle; external ones stay up until the sequencer goes busy
   task automatic xfer(input logic [3:0] m, input logic [23:0] a, input logic [15:0] d);
      int n;
      @(posedge clk);
      cpu_req <= 1'h1;
      {cpu_write, cpu_word, cpu_direct} <= m[3:1];
      cpu_addr <= a;
      cpu_wdata <= d;
      @(posedge clk);
      if (!m[0])
         cpu_req <= 1'h0;
      #1;
      for (n = 0; m[0] && !cpu_busy && n < 8; n++) begin
         @(posedge clk);
         #1;
      end
      if (m[0]) begin
         chk("address pins", a, {hi_o, mid_o, addr_lo});
         chk("read write", !m[3], read_write);
         vec = vector_access;
      end
      for (lat = 0; !cpu_ack && lat < 40; lat++) begin
         @(posedge clk);
         if (lat == 0)
            cpu_req <= 1'h0;
         #1;
      end
      q = cpu_rdata;
   endtask

   task automatic t_reset;
      logic p;
      @(posedge clk);
      #1;
      chk("grant", 1'h0, bus_hold_grant);
      chk("enable", 1'h1, enable_n);
      for (int i = 0; i < xbi_pkg::XBI_NPORT; i++)
         chk("port direction", 8'hFF, port_oe_n[i]);
      for (int i = 0; i < 3; i++) begin
         p = phi1_out;
         @(posedge clk);
         #1;
         chk("clock output", !p, phi1_out);
      end
      $display("test reset done");
   endtask

   task automatic t_ram;
      xfer(4'hC, 24'h000080, 16'hBEEF);
      chk("ram latency", 24'h0, lat);
      xfer(4'h8, 24'h00087F, 16'h975A);
      xfer(4'h4, 24'h000080, 16'h0000);
      chk("ram word", 16'hBEEF, q);
      xfer(4'h0, 24'h00087F, 16'h0000);
      chk("ram top byte", 16'h005A, q);
      @(posedge clk) direct_page_base <= 16'h0700;
      xfer(4'hA, 24'h000010, 16'h0033);
      xfer(4'h0, 24'h000710, 16'h0000);
      chk("direct page", 16'h0033, q);
      $display("test ram done");
   endtask

   task automatic t_regs;
      for (int i = 0; i < xbi_pkg::XBI_NPORT; i++) begin
         xfer(4'h8, {17'h0, xbi_pkg::XBI_PORT_DIR_OFF[i]}, 16'h00FF);
         xfer(4'h0, {17'h0, xbi_pkg::XBI_PORT_DIR_OFF[i]}, 16'h0000);
         chk("direction read", xbi_pkg::XBI_PORT_MASK[i], q);
         chk("port enable", 8'(~xbi_pkg::XBI_PORT_MASK[i]), port_oe_n[i]);
      end
      xfer(4'hC, 24'h00000A, 16'hA55A);
      xfer(4'h4, 24'h00000A, 16'h0000);
      chk("port word", {8'hA5, 8'h5A & xbi_pkg::XBI_PORT_MASK[0]}, q);
      chk("port output", 8'hA5, port_o[1]);
      xfer(4'h0, 24'h000015, 16'h0000);
      chk("unmapped register", 24'h0, q);
      chk("register latency", 24'h0, lat);
      $display("test registers done");
   endtask

   task automatic t_ext;
      for (int w8 = 0; w8 < 2; w8++) begin
         @(posedge clk);
         bus_width_8 <= w8[0];
         xfer(4'hD, 24'h123456, 16'hA1B2);
         chk("word latency", w8 ? 24'h8 : 24'h4, lat);
         chk("vector flag", 1'h0, vec);
         xfer(4'h5, 24'h123456, 16'h0000);
         chk("ext word", 16'hA1B2, q);
         xfer(4'hD, 24'h020001, 16'h3C4D);
         chk("odd word latency", 24'h8, lat);
         xfer(4'h1, 24'h020002, 16'h0000);
         chk("odd word high byte", 16'h003C, q);
      end
      $display("test external done");
   endtask

   task automatic t_wait;
      @(posedge clk);
      bus_width_8 <= 1'h0;
      slow <= 1'h1;
      xfer(4'h5, 24'h123456, 16'h0000);
      chk("wait latency", 24'h8, lat);
      chk("wait data", 16'hA1B2, q);
      @(posedge clk);
      slow <= 1'h0;
      $display("test wait done");
   endtask

   task automatic t_vec;
      xfer(4'hD, 24'h00FFD6, 16'h0000);
      xfer(4'h5, 24'h00FFD6, 16'h0000);
      chk("vector flag", 1'h1, vec);
      chk("vector data", 16'hD7D6, q);
      $display("test vectors done");
   endtask

   task automatic t_hold;
      @(posedge clk);
      hold_req_n <= 1'h0;
      @(posedge clk);
      #1;
      chk("grant", 1'h1, bus_hold_grant);
      chk("control released", 1'h1, ctrl_oe_n);
      chk("data released", 1'h1, mid_oe_n & hi_oe_n);
      @(posedge clk);
      cpu_req <= 1'h1;
      {cpu_write, cpu_word, cpu_direct} <= 3'h0;
      cpu_addr <= 24'h000080;
      repeat (3) begin
         @(posedge clk);
         #1;
         chk("ack in hold", 1'h0, cpu_ack);
      end
      @(posedge clk);
      cpu_req <= 1'h0;
      hold_req_n <= 1'h1;
      @(posedge clk);
      #1;
      chk("grant released", 1'h0, bus_hold_grant);
      $display("test hold done");
   endtask

   initial begin
      {reset, cpu_req, cpu_write, cpu_word, cpu_direct, bus_width_8, hold_req_n, slow} = 8'h82;
      {cpu_addr, cpu_wdata, direct_page_base, port_i} = '0;
      repeat (12) @(posedge clk);
      reset <= 1'h0;
      t_reset();
      t_ram();
      t_regs();
      t_ext();
      t_wait();
      t_vec();
      t_hold();
      conclude();
   end
endmodule

`default_nettype wire
